// File: rtl/scm_consts.svh
// Constants of the speed class recording monitor
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH
`define SCM_CLK_MHZ 200
`define SCM_MS_US 1000
`define SCM_MS_CYC (`SCM_CLK_MHZ * `SCM_MS_US)
`define SCM_WIN 8
`define SCM_UPD_MAX_MS 750
`define SCM_UPD_AVE_MS 100
`define SCM_RD4K_MAX_MS 12
`define SCM_REC_BSY_MS 1000
`define SCM_CI_MAX_MS 250
`define SCM_QUAL_DS_MHZ 20
`define SCM_QUAL_HS_MHZ 40
`define SCM_AU_MAX_MB 64
`define SCM_SUB_MB 4
`define SCM_BYTES_PER_MB 1048576
`define SCM_WORD_BYTES 4
`define SCM_SUB_WORDS (`SCM_SUB_MB * `SCM_BYTES_PER_MB / `SCM_WORD_BYTES)
`define SCM_CAP_CMD20_BIT 32
`define SCM_FIFO_DEPTH 4
`define SCM_DATA_W 32
`endif

// File: rtl/scm_pkg.sv
// Types of the speed class recording monitor
package scm_pkg;
  typedef enum logic [1:0] {
    SCM_C2 = 2'b00,
    SCM_C4 = 2'b01,
    SCM_C6 = 2'b10,
    SCM_C10 = 2'b11
  } scm_class_t;
  typedef enum logic [1:0] {
    SCM_ST_IDLE = 2'b00,
    SCM_ST_UPD = 2'b01,
    SCM_ST_RECBSY = 2'b10,
    SCM_ST_CI = 2'b11
  } scm_state_t;
endpackage

// File: rtl/scm_monitor.sv
// Speed class recording monitor with its stream FIFO
`include "scm_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module scm_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // Storage words
  logic [AW-1:0] wp_r; // Write pointer
  logic [AW-1:0] rp_r; // Read pointer
  logic [AW:0] cnt_r; // Fill level
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  // Flags come from the fill level so full and empty are exact
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rp_r];

  // Next fill level
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Pointers, level and registered handshake flags
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready_o <= (cnt_nxt != (AW + 1)'(D));
      out_valid_o <= (cnt_nxt != '0);
    end
  end

  // Data store, no reset needed
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end
endmodule // scm_fifo

module scm_monitor import scm_pkg::*; #(
  parameter int MS_CYC = `SCM_MS_CYC
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd20_strap_i, // Command 20 built in
  input wire logic hs_capable_i, // High speed mode built in
  input wire logic ext_cap_i, // Extended-capacity card
  input wire logic [1:0] card_class_i, // Claimed class
  input wire logic [1:0] cond_class_i, // Conditions applied
  input wire logic hs_mode_i, // Bus runs high speed
  input wire logic [6:0] au_size_mb_i, // Allocation unit size
  input wire logic upd_start_i, // First metadata write taken
  input wire logic upd_done_i, // Busy released after third
  input wire logic rec_start_i, // Start recording received
  input wire logic ci_start_i, // Continuity info write taken
  input wire logic busy_done_i, // Card busy released
  input wire logic rd_start_i, // Metadata read started
  input wire logic rd_done_i, // Metadata read ended
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [`SCM_DATA_W-1:0] in_data_i,
  output logic media_valid_o,
  input wire logic media_ready_i,
  output logic [`SCM_DATA_W-1:0] media_data_o,
  output logic [63:0] cap_word_o, // Capability register image
  output logic [3:0] write_rate_floor_o, // MB/s
  output logic [3:0] read_rate_floor_o, // MB/s
  output logic [3:0] move_rate_floor_o, // MB/s
  output logic [3:0] move_rate_rep_o, // Reported move rate
  output logic [5:0] qual_clk_mhz_o, // Qualifying bus clock
  output logic [9:0] upd_ave_ms_o, // Worst sliding mean
  output logic [31:0] worst_sub_cyc_o, // Slowest 4MB sub-unit
  output logic cfg_err_o,
  output logic au_err_o,
  output logic upd_max_err_o,
  output logic upd_ave_err_o,
  output logic worst_rep_err_o,
  output logic rate_err_o,
  output logic rd_err_o,
  output logic rec_bsy_err_o,
  output logic ci_err_o
);
  logic [17:0] div_r; // Millisecond divider
  logic ms_tick_r; // One-cycle millisecond enable
  scm_state_t st_r; // Update sequencer state
  scm_state_t st_nxt;
  logic [9:0] tmr_ms_r; // Timer of current sequence
  logic [9:0] rd_ms_r; // Metadata read timer
  logic rd_act_r;
  logic [9:0] hist [`SCM_WIN]; // Last update durations
  logic [2:0] hp_r; // History pointer
  logic [3:0] fill_r; // Cycles seen, saturating at window
  logic [12:0] sum_r; // Window sum
  logic [12:0] sum_nxt;
  logic [12:0] max_sum_r; // Largest window sum
  logic [3:0] wc_r; // Worst-case cycles in window
  logic [3:0] wc_nxt;
  logic upd_end;
  logic f_ready; // FIFO may drain
  logic f_valid;
  logic [`SCM_DATA_W-1:0] f_data;
  logic [19:0] sub_wd_r; // Words in current sub-unit
  logic [31:0] sub_cyc_r; // Busy cycles in sub-unit
  logic beat;
  logic strap_done_r;
  scm_class_t cls_eff;

  // Class number in MB/s; shared by write and read floors
  function automatic logic [3:0] cls_mbs(input logic [1:0] c);
    unique case (c)
      2'b00: cls_mbs = 4'h2;
      2'b01: cls_mbs = 4'h4;
      2'b10: cls_mbs = 4'h6;
      2'b11: cls_mbs = 4'ha;
    endcase
  endfunction

  // Cycles a sub-unit may take at the floor of a class
  function automatic logic [31:0] sub_lim(input logic [1:0] c);
    sub_lim = 32'(`SCM_SUB_MB * `SCM_CLK_MHZ * 64'(`SCM_BYTES_PER_MB) / cls_mbs(c));
  endfunction

  // Conditions never above the claimed class
  assign cls_eff = (cond_class_i > card_class_i) ? scm_class_t'(card_class_i)
                                                 : scm_class_t'(cond_class_i);

  // Millisecond enable; long count is a parameter for short sims
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (div_r == 18'(MS_CYC - 1));
      div_r <= (div_r == 18'(MS_CYC - 1)) ? '0 : div_r + 1'b1;
    end
  end

  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SCM_ST_IDLE: begin
        if (upd_start_i) begin
          st_nxt = SCM_ST_UPD;
        end else if (rec_start_i) begin
          st_nxt = SCM_ST_RECBSY;
        end else if (ci_start_i) begin
          st_nxt = SCM_ST_CI;
        end
      end
      SCM_ST_UPD: begin
        if (upd_done_i) begin
          st_nxt = SCM_ST_IDLE;
        end
      end
      SCM_ST_RECBSY, SCM_ST_CI: begin
        if (busy_done_i) begin
          st_nxt = SCM_ST_IDLE;
        end
      end
    endcase
  end

  assign upd_end = (st_r == SCM_ST_UPD) && upd_done_i;

  // State and sequence timer, saturating in ms
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r <= SCM_ST_IDLE;
      tmr_ms_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_r == SCM_ST_IDLE) begin
        tmr_ms_r <= '0;
      end else if (ms_tick_r && tmr_ms_r != 10'h3ff) begin
        tmr_ms_r <= tmr_ms_r + 1'b1;
      end
    end
  end

  // Window sum and worst-case count with the outgoing entry removed
  always_comb begin
    sum_nxt = sum_r - 13'(hist[hp_r]) + 13'(tmr_ms_r);
    wc_nxt = wc_r;
    if (hist[hp_r] >= 10'(`SCM_UPD_MAX_MS)) begin
      wc_nxt = wc_nxt - 1'b1;
    end
    if (tmr_ms_r >= 10'(`SCM_UPD_MAX_MS)) begin
      wc_nxt = wc_nxt + 1'b1;
    end
  end

  // History of update durations, cleared so the first window sums right
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < `SCM_WIN; i++) begin
        hist[i] <= '0;
      end
    end else if (upd_end) begin
      hist[hp_r] <= tmr_ms_r;
    end
  end

  // Sliding sum, its maximum once the window is full
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      hp_r <= '0;
      fill_r <= '0;
      sum_r <= '0;
      max_sum_r <= '0;
      wc_r <= '0;
      upd_ave_ms_o <= '0;
    end else if (upd_end) begin
      hp_r <= hp_r + 1'b1;
      sum_r <= sum_nxt;
      wc_r <= wc_nxt;
      if (fill_r != 4'(`SCM_WIN)) begin
        fill_r <= fill_r + 1'b1;
      end
      // Mean is only defined over a whole window of cycles
      if (fill_r >= 4'(`SCM_WIN - 1) && sum_nxt > max_sum_r) begin
        max_sum_r <= sum_nxt;
        upd_ave_ms_o <= sum_nxt[12:3];
      end
    end
  end

  // Timing errors, sticky until reset
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      upd_max_err_o <= 1'b0;
      upd_ave_err_o <= 1'b0;
      worst_rep_err_o <= 1'b0;
      rec_bsy_err_o <= 1'b0;
      ci_err_o <= 1'b0;
    end else begin
      if (st_r == SCM_ST_UPD && tmr_ms_r > 10'(`SCM_UPD_MAX_MS)) begin
        upd_max_err_o <= 1'b1;
      end
      if (upd_end && wc_nxt > 4'h1) begin
        worst_rep_err_o <= 1'b1;
      end
      if (max_sum_r > 13'(`SCM_UPD_AVE_MS * `SCM_WIN)) begin
        upd_ave_err_o <= 1'b1;
      end
      if (st_r == SCM_ST_RECBSY && tmr_ms_r > 10'(`SCM_REC_BSY_MS)) begin
        rec_bsy_err_o <= 1'b1;
      end
      if (st_r == SCM_ST_CI && tmr_ms_r > 10'(`SCM_CI_MAX_MS)) begin
        ci_err_o <= 1'b1;
      end
    end
  end

  // Metadata read timer runs beside the sequencer
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rd_act_r <= 1'b0;
      rd_ms_r <= '0;
      rd_err_o <= 1'b0;
    end else begin
      if (rd_start_i) begin
        rd_act_r <= 1'b1;
        rd_ms_r <= '0;
      end else if (rd_done_i) begin
        rd_act_r <= 1'b0;
      end else if (rd_act_r && ms_tick_r && rd_ms_r != 10'h3ff) begin
        rd_ms_r <= rd_ms_r + 1'b1;
      end
      if (rd_act_r && rd_ms_r > 10'(`SCM_RD4K_MAX_MS)) begin
        rd_err_o <= 1'b1;
      end
    end
  end

  // Stream buffer; its ready reaches the source as back-pressure
  scm_fifo #(
    .W(`SCM_DATA_W),
    .D(`SCM_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o),
    .in_data_i(in_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );

  // Media stalls during an update, so stream waits in the buffer
  assign f_ready = (st_r != SCM_ST_UPD) && (!media_valid_o || media_ready_i);
  assign beat = media_valid_o && media_ready_i;

  // Output stage keeps media port straight from flops
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      media_valid_o <= 1'b0;
      media_data_o <= '0;
    end else if (!media_valid_o || media_ready_i) begin
      media_valid_o <= f_valid && f_ready;
      media_data_o <= f_data;
    end
  end

  // Sub-unit timing counts only cycles with data offered, so gaps
  // on the source side do not lower the measured rate
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sub_wd_r <= '0;
      sub_cyc_r <= '0;
      worst_sub_cyc_o <= '0;
      rate_err_o <= 1'b0;
    end else begin
      if (media_valid_o && sub_cyc_r != 32'hffffffff) begin
        sub_cyc_r <= sub_cyc_r + 1'b1;
      end
      if (beat) begin
        if (sub_wd_r == 20'(`SCM_SUB_WORDS - 1)) begin
          sub_wd_r <= '0;
          sub_cyc_r <= '0;
          if (sub_cyc_r > worst_sub_cyc_o) begin
            worst_sub_cyc_o <= sub_cyc_r;
          end
          if (sub_cyc_r > sub_lim(cls_eff)) begin
            rate_err_o <= 1'b1;
          end
        end else begin
          sub_wd_r <= sub_wd_r + 1'b1;
        end
      end
    end
  end

  // Capability word built once after reset release
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      strap_done_r <= 1'b0;
      cap_word_o <= '0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      cap_word_o[`SCM_CAP_CMD20_BIT] <= cmd20_strap_i;
    end
  end

  // Floors, reported move rate and configuration checks
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      write_rate_floor_o <= '0;
      read_rate_floor_o <= '0;
      move_rate_floor_o <= '0;
      move_rate_rep_o <= '0;
      qual_clk_mhz_o <= '0;
      cfg_err_o <= 1'b0;
      au_err_o <= 1'b0;
    end else begin
      write_rate_floor_o <= cls_mbs(cls_eff);
      read_rate_floor_o <= cls_mbs(cls_eff);
      // Half the write floor; class 10 conditions carry no move floor
      move_rate_floor_o <= (cls_eff == SCM_C10) ? 4'h0
                           : (cls_mbs(cls_eff) >> 1);
      // Class 10 and extended cards report zero; host reads it as such
      if (ext_cap_i || card_class_i == SCM_C10) begin
        move_rate_rep_o <= 4'h0;
      end else begin
        move_rate_rep_o <= cls_mbs(card_class_i) >> 1;
      end
      qual_clk_mhz_o <= (cls_eff == SCM_C10) ? 6'(`SCM_QUAL_HS_MHZ)
                                             : 6'(`SCM_QUAL_DS_MHZ);
      cfg_err_o <= (card_class_i == SCM_C10 && !hs_capable_i)
                   || (cls_eff == SCM_C10 && !hs_mode_i);
      au_err_o <= ext_cap_i && ((au_size_mb_i > 7'(`SCM_AU_MAX_MB))
                  || (au_size_mb_i > 7'(`SCM_SUB_MB)
                      && au_size_mb_i[1:0] != 2'h0));
    end
  end
endmodule // scm_monitor

`default_nettype wire

// File: dv/scm_monitor_chk.sv
// Port checker of the speed class recording monitor, bound to its top module
`include "scm_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module scm_monitor_chk import scm_pkg::*; #(
  parameter int MS_CYC = `SCM_MS_CYC
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd20_strap_i,
  input wire logic hs_capable_i,
  input wire logic ext_cap_i,
  input wire logic [1:0] card_class_i,
  input wire logic [6:0] au_size_mb_i,
  input wire logic upd_start_i,
  input wire logic upd_done_i,
  input wire logic rec_start_i,
  input wire logic ci_start_i,
  input wire logic busy_done_i,
  input wire logic media_valid_o,
  input wire logic media_ready_i,
  input wire logic [`SCM_DATA_W-1:0] media_data_o,
  input wire logic [63:0] cap_word_o,
  input wire logic [3:0] write_rate_floor_o,
  input wire logic [3:0] read_rate_floor_o,
  input wire logic [3:0] move_rate_rep_o,
  input wire logic [5:0] qual_clk_mhz_o,
  input wire logic cfg_err_o,
  input wire logic au_err_o,
  input wire logic upd_max_err_o,
  input wire logic rec_bsy_err_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [1:0] post_r; // Cycles since reset release, saturating at 3
  logic upd_r; // Update sequence open
  logic oth_r; // Start-recording or continuity sequence open
  logic [31:0] seq_r; // Cycles since the open sequence began
  logic idle; // No sequence open
  assign idle = !upd_r && !oth_r;
  // Mirror of the one-at-a-time sequencer, so each sequence can be timed
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      post_r <= 2'h0;
      upd_r <= 1'b0;
      oth_r <= 1'b0;
      seq_r <= 32'h0;
    end else begin
      if (post_r != 2'h3) begin
        post_r <= post_r + 2'h1;
      end
      if (idle && (upd_start_i || rec_start_i || ci_start_i)) begin
        upd_r <= upd_start_i; // Update wins over the other starts
        oth_r <= !upd_start_i;
        seq_r <= 32'h0;
      end else begin
        seq_r <= idle ? seq_r : seq_r + 32'h1; // Held after close for late flags
        if (upd_r && upd_done_i) begin
          upd_r <= 1'b0;
        end
        if (oth_r && busy_done_i) begin
          oth_r <= 1'b0;
        end
      end
    end
  end
  cap_image_a: assert property (post_r == 2'h3 |-> cap_word_o[31:0] == 32'h0 &&
    cap_word_o[63:33] == 31'h0 && cap_word_o[32] == cmd20_strap_i) else $error("cap word bad");
  floor_order_a: assert property (post_r == 2'h3 |-> write_rate_floor_o != 4'h0 &&
    read_rate_floor_o >= write_rate_floor_o) else $error("read floor below write floor");
  qual_clock_a: assert property (post_r == 2'h3 |-> qual_clk_mhz_o ==
    ((write_rate_floor_o == 4'ha) ? 6'h28 : 6'h14)) else $error("qualifying clock bad");
  move_zero_a: assert property (post_r == 2'h3 && $past(ext_cap_i) |->
    move_rate_rep_o == 4'h0) else $error("move rate not zero");
  hs_needed_a: assert property (post_r == 2'h3 && $stable(card_class_i) &&
    $stable(hs_capable_i) && card_class_i == SCM_C10 && !hs_capable_i |-> cfg_err_o)
    else $error("class 10 without high speed not flagged");
  au_size_a: assert property (post_r == 2'h3 && $stable(au_size_mb_i) &&
    $stable(ext_cap_i) |-> au_err_o == (ext_cap_i && (au_size_mb_i > 7'h40 ||
    (au_size_mb_i > 7'h04 && au_size_mb_i[1:0] != 2'h0)))) else $error("unit size flag bad");
  stream_hold_a: assert property (media_valid_o && !media_ready_i |=>
    media_valid_o && $stable(media_data_o)) else $error("stream word dropped");
  upd_late_a: assert property ($rose(upd_max_err_o) |-> seq_r > 750 * MS_CYC)
    else $error("update limit flagged early");
  upd_bound_a: assert property (upd_r && seq_r == 753 * MS_CYC |-> ##[0:4] upd_max_err_o)
    else $error("update limit missed");
  rec_late_a: assert property ($rose(rec_bsy_err_o) |-> seq_r > 1000 * MS_CYC)
    else $error("recording busy flagged early");
  cover property ($rose(upd_max_err_o));
  cover property ($rose(rec_bsy_err_o));
  cover property ($rose(au_err_o));
  cover property (media_valid_o && media_ready_i);
endmodule // scm_monitor_chk
bind scm_monitor scm_monitor_chk #(.MS_CYC(MS_CYC)) i_chk (.core_clk_i, .sys_rst_i,
  .cmd20_strap_i, .hs_capable_i, .ext_cap_i, .card_class_i, .au_size_mb_i, .upd_start_i,
  .upd_done_i, .rec_start_i, .ci_start_i, .busy_done_i, .media_valid_o, .media_ready_i,
  .media_data_o, .cap_word_o, .write_rate_floor_o, .read_rate_floor_o, .move_rate_rep_o,
  .qual_clk_mhz_o, .cfg_err_o, .au_err_o, .upd_max_err_o, .rec_bsy_err_o);
`default_nettype wire

// File: dv/scm_card_model.sv
// Behavioural card side of the stream: takes words promptly, slowly or not at all
`timescale 1ns/10ps
`default_nettype none
module scm_card_model (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic stall_i, // Card busy, stream held off
  input wire logic slow_i, // Card takes one word in four
  output logic media_ready_o
);
  logic [1:0] ph_r; // Phase of the slow acceptance pattern
  // Free-running phase; a slow card leaves gaps the monitor must ride out
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ph_r <= 2'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
    end
  end
  // A prompt card keeps the bus fully busy, as rates are qualified that way
  assign media_ready_o = !sys_rst_i && !stall_i && (!slow_i || ph_r == 2'h0);
endmodule // scm_card_model
`default_nettype wire

// File: dv/speed_class_recording_monitor_tb.sv
// Self-checking testbench of the speed class recording monitor
`include "scm_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module speed_class_recording_monitor_tb import scm_pkg::*;;
  localparam int MS = 4; // Shortened millisecond in clock cycles
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic strap = 1'b1, hs_cap = 1'b1, ext = 1'b0, hs_mode = 1'b1;
  logic [1:0] card = 2'h3, cond = 2'h3;
  logic [6:0] au = 7'h04;
  logic upd_s = 1'b0, upd_d = 1'b0, rec_s = 1'b0, ci_s = 1'b0, bdone = 1'b0;
  logic rd_s = 1'b0, rd_d = 1'b0, in_valid = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [31:0] in_data = 32'h0;
  logic in_ready, media_valid, media_ready, cfg_e, au_e, umax_e, uave_e, rep_e, rec_e, rd_e, ci_e;
  logic [31:0] media_data;
  logic [63:0] cap;
  logic [3:0] wf, rf, mf, mr;
  logic [5:0] qc;
  logic [9:0] ave;
  logic [31:0] worst;
  logic rate_e;
  int num_errors = 0, n_checks = 0;
  logic [31:0] q[$]; // Words expected at the card, in order
  int hist[$]; // Durations of the last eight updates
  int maxsum = 0, e_max = 0, e_rep = 0, e_ave = 0;
  scm_monitor #(.MS_CYC(MS)) i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .cmd20_strap_i(strap), .hs_capable_i(hs_cap), .ext_cap_i(ext), .card_class_i(card),
    .cond_class_i(cond), .hs_mode_i(hs_mode), .au_size_mb_i(au), .upd_start_i(upd_s),
    .upd_done_i(upd_d), .rec_start_i(rec_s), .ci_start_i(ci_s), .busy_done_i(bdone),
    .rd_start_i(rd_s), .rd_done_i(rd_d), .in_valid_i(in_valid), .in_ready_o(in_ready),
    .in_data_i(in_data), .media_valid_o(media_valid), .media_ready_i(media_ready),
    .media_data_o(media_data), .cap_word_o(cap), .write_rate_floor_o(wf),
    .read_rate_floor_o(rf), .move_rate_floor_o(mf), .move_rate_rep_o(mr), .qual_clk_mhz_o(qc),
    .upd_ave_ms_o(ave), .worst_sub_cyc_o(worst), .cfg_err_o(cfg_e), .au_err_o(au_e),
    .upd_max_err_o(umax_e), .upd_ave_err_o(uave_e), .worst_rep_err_o(rep_e), .rate_err_o(rate_e),
    .rd_err_o(rd_e), .rec_bsy_err_o(rec_e), .ci_err_o(ci_e));
  scm_card_model i_card (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .stall_i(stall),
    .slow_i(slow), .media_ready_o(media_ready));
  // 200 MHz clock
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic int fl(input int c); // Floor in MB/s for a class code
    return (c == 3) ? 10 : (c + 1) * 2;
  endfunction
  // One timed sequence: 0 update, 1 start recording, 2 continuity write, 3 metadata read
  task automatic run_seq(input int kind, input int ms);
    @(negedge core_clk_i);
    case (kind)
      0: upd_s = 1'b1;
      1: rec_s = 1'b1;
      2: ci_s = 1'b1;
      default: rd_s = 1'b1;
    endcase
    @(negedge core_clk_i);
    {upd_s, rec_s, ci_s, rd_s} = 4'h0;
    // Exactly ms*MS edges in the window, so exactly ms ticks whatever their phase
    repeat (ms * MS) @(negedge core_clk_i);
    case (kind)
      0: upd_d = 1'b1;
      3: rd_d = 1'b1;
      default: bdone = 1'b1;
    endcase
    @(negedge core_clk_i);
    {upd_d, rd_d, bdone} = 3'h0;
    repeat (2) @(negedge core_clk_i);
  endtask
  // Update with a sliding eight-entry reference of sums and flags
  task automatic upd_once(input int ms);
    int s;
    int n;
    run_seq(0, ms);
    hist.push_back(ms);
    if (hist.size() > 8) void'(hist.pop_front());
    if (ms > 750) e_max = 1;
    s = 0;
    n = 0;
    foreach (hist[i]) begin
      s += hist[i];
      n += (hist[i] >= 750);
    end
    if (n > 1) e_rep = 1;
    if (hist.size() == 8 && s > maxsum) maxsum = s;
    if (maxsum > 800) e_ave = 1;
    chk(ave, maxsum / 8);
    chk({umax_e, rep_e, uave_e}, {e_max[0], e_rep[0], e_ave[0]});
  endtask
  // Offer one word and hold it until taken, giving up after eight edges
  task automatic push1(output bit ok);
    @(negedge core_clk_i);
    in_valid = 1'b1;
    in_data = $urandom;
    ok = 1'b0;
    for (int t = 0; t < 8 && !ok; t++) begin
      @(posedge core_clk_i);
      ok = in_ready;
    end
    if (ok) q.push_back(in_data);
  endtask
  // Scoreboard at every word the card takes
  always @(posedge core_clk_i) begin
    if (!sys_rst_i && media_valid && media_ready) begin
      if (q.size() == 0) chk(1, 0);
      else chk(media_data, q.pop_front());
    end
  end
  // Watchdog sized well above the expected run of about 18000 cycles
  initial begin
    repeat (90000) @(posedge core_clk_i);
    num_errors++;
    close_out();
  end
  initial begin
    int e;
    int cnt;
    bit ok;
    int aus[6];
    int lims[4];
    logic [2:0] bsy;
    aus = '{4, 8, 10, 64, 68, 2};
    lims = '{0, 1000, 250, 12};
    bsy = 3'h0;
    void'($urandom(32'hb7ef));
    repeat (3) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk(cap, 64'h1 << `SCM_CAP_CMD20_BIT);
    for (int i = 0; i < 16; i++) begin
      card = 2'(i >> 2);
      cond = 2'(i);
      {hs_cap, hs_mode, ext} = 3'($urandom);
      repeat (3) @(negedge core_clk_i);
      e = (cond < card) ? cond : card;
      chk(wf, fl(e));
      chk(rf, fl(e));
      chk(mf, (e == 3) ? 0 : fl(e) / 2);
      chk(mr, (ext || card == 3) ? 0 : fl(card) / 2);
      chk(qc, (e == 3) ? 40 : 20);
      chk(cfg_e, (card == 3 && !hs_cap) || (e == 3 && !hs_mode));
    end
    {card, cond, hs_cap, hs_mode} = 6'h3f;
    foreach (aus[i]) begin
      au = 7'(aus[i]);
      ext = (i % 2 == 1) || 1'($urandom);
      repeat (3) @(negedge core_clk_i);
      chk(au_e, ext && (aus[i] > 64 || (aus[i] > 4 && aus[i] % 4 != 0)));
    end
    stall = 1'b1;
    cnt = 0;
    ok = 1'b1;
    while (ok) begin
      push1(ok);
      cnt += ok;
    end
    @(negedge core_clk_i);
    in_valid = 1'b0;
    chk(cnt, `SCM_FIFO_DEPTH + 1);
    chk(in_ready, 0);
    stall = 1'b0;
    for (int m = 1; m >= 0; m--) begin
      slow = 1'(m);
      repeat (12) push1(ok); // Words sent in order, never split
      @(negedge core_clk_i);
      in_valid = 1'b0;
    end
    repeat (40) @(negedge core_clk_i);
    chk({q.size() == 0, media_valid}, 2'b10);
    // Far less than one whole sub-unit has passed, so none is measured yet
    chk({worst, rate_e}, 33'h0);
    repeat (9) upd_once(1 + $urandom % 100);
    upd_once(760);
    upd_once(750);
    upd_once(20);
    for (int k = 1; k < 4; k++) begin
      run_seq(k, lims[k] - 2);
      chk({rec_e, ci_e, rd_e}, bsy);
      bsy |= 3'h1 << (3 - k);
      run_seq(k, lims[k] + 2);
      chk({rec_e, ci_e, rd_e}, bsy);
    end
    close_out();
  end
endmodule // speed_class_recording_monitor_tb
`default_nettype wire
